// >>> include/chip_cfg_pkg.sv
// Package of offsets, field positions, reset values and bus carrier types for the chip configuration block.
`default_nettype none
package chip_cfg_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 64;
    localparam int GBUS_ADDR_W = 36;
    localparam int STRAP_W = 8;

    // Register byte offsets.
    localparam logic [15:0] OFS_CHIP_CONFIG = 16'hE000;
    localparam logic [15:0] OFS_CHIP_REVISION_ID = 16'hE008;
    localparam logic [15:0] OFS_PIN_CONFIG = 16'hE010;
    localparam logic [15:0] OFS_TIMEOUT_ERROR_ADDR = 16'hE018;
    localparam logic [15:0] OFS_CLOCK_GATING_CONTROL = 16'hE020;
    localparam logic [15:0] OFS_INTERNAL_BUS_ARBITER_CTRL = 16'hE030;
    localparam logic [15:0] OFS_REGISTER_BASE_MAPPING = 16'hE048;
    localparam logic [15:0] OFS_IRQ_STATUS = 16'hE080;
    localparam logic [15:0] OFS_IRQ_MASK = 16'hE088;

    // Field positions inside chip_config.
    localparam int POS_WATCHDOG_RESET_FLAG = 41;
    localparam int POS_WATCHDOG_RESET_PIN_EN = 40;
    localparam int POS_BOOT_STRAP_LO = 32;
    localparam int POS_TIMEOUT_LENGTH_LO = 25;
    localparam int POS_CORE_TIMER_IRQ_DIS = 24;
    localparam int POS_WRITE_TIMEOUT_ERR = 16;
    localparam int POS_TIMEOUT_DETECT_EN = 14;

    localparam logic [1:0] TIMEOUT_LENGTH_RESET = 2'h3;
    localparam int STRAP_CORE_TIMER_BIT = 7;

    // Timeout limits in internal bus clock cycles, one per length code.
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] LIMIT_512 = 13'h0200;
    localparam logic [CNT_W-1:0] LIMIT_1024 = 13'h0400;
    localparam logic [CNT_W-1:0] LIMIT_2048 = 13'h0800;
    localparam logic [CNT_W-1:0] LIMIT_4096 = 13'h1000;

    // Interrupt status bit positions.
    localparam int IRQ_CORE_WRITE = 0;
    localparam int IRQ_CORE_READ = 1;
    localparam int IRQ_OTHER_MASTER = 2;
    localparam int IRQ_W = 3;

    typedef enum logic [1:0] {
        MST_CORE,
        MST_PCI,
        MST_DMA
    } bus_master_t;

    typedef struct packed {
        logic [GBUS_ADDR_W-1:0] addr;
        logic write;
        bus_master_t master;
    } gbus_access_t;
endpackage
`default_nettype wire

// >>> hw/chip_config_bus_timeout.sv
// Chip configuration registers with the internal bus timeout monitor.
`default_nettype none
// Functional notes
// R1: An internal bus access ends only on a target response or the monitor's error.
// R2: Timeout monitor works only while the detect enable bit is set.
// R3: Length field 26:25 selects 512/1024/2048/4096 cycles, resets to 11, read/write.
// R4: No response within the limit makes the monitor answer the master with error.
// R5: Each timeout captures the access address into the error address register.
// R6: Core write timeout sets the write error flag, feeding interrupt source 1; the code sets interrupt status bit 0 instead.
// R7: Core read timeout is raised to the core as a bus error exception.
// R8: Timeout of another master sets an error bit inside that master.
// R9: Deasserted test reset means a probe is attached, so detection is off.
// R10: Bit 41 flags a watchdog reset, write one clears, only chip reset initialises.
// R11: Bit 40 enables the external watchdog reset pin, reset 0, chip reset only.
// R12: Bits 39:32 are read-only boot straps latched from data pins 15:8.
// R13: Bit 24 is read-only core timer irq disable, the inverse of data pin 7.
// R14: Timeout counter restarts on each access and stops on response or error.
module chip_config_bus_timeout #(
    parameter logic [63:0] REVISION_ID = 64'h0000_0000_0000_0001 // Arbitrary value.
) (
    // Clock and resets
    input wire logic mclk,
    input wire logic srst,
    input wire logic boot_rst,
    // Register port
    input wire logic [chip_cfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [chip_cfg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [chip_cfg_pkg::DATA_W-1:0] reg_rdata,
    // Internal bus monitor
    input wire logic gbus_start,
    input wire chip_cfg_pkg::gbus_access_t gbus_access,
    input wire logic gbus_ack,
    output logic gbus_err_resp,
    output logic core_bus_error,
    output logic pci_timeout_err,
    output logic dma_timeout_err,
    // Pins and straps
    input wire logic jtag_trst_n,
    input wire logic [15:0] strap_data,
    input wire logic watchdog_reset_req,
    output logic watchdog_reset_out_n,
    output logic core_timer_irq_disable,
    // Interrupts
    output logic write_err_irq,
    output logic irq
);
    typedef enum logic {
        MON_IDLE,
        MON_BUSY
    } mon_state_t;

    // Pin synchronisers.
    logic [15:0] strap_meta_reg, strap_sync_reg;
    logic trst_meta_reg, trst_sync_reg;
    always_ff @(posedge mclk) begin
        strap_meta_reg <= strap_data;
        strap_sync_reg <= strap_meta_reg;
        trst_meta_reg <= jtag_trst_n;
        trst_sync_reg <= trst_meta_reg;
    end

    // Register decode.
    wire logic sel_chip_config = reg_addr == chip_cfg_pkg::OFS_CHIP_CONFIG;
    wire logic sel_rev = reg_addr == chip_cfg_pkg::OFS_CHIP_REVISION_ID;
    wire logic sel_pin_config = reg_addr == chip_cfg_pkg::OFS_PIN_CONFIG;
    wire logic sel_timeout_error_addr = reg_addr == chip_cfg_pkg::OFS_TIMEOUT_ERROR_ADDR;
    wire logic sel_clk = reg_addr == chip_cfg_pkg::OFS_CLOCK_GATING_CONTROL;
    wire logic sel_arb = reg_addr == chip_cfg_pkg::OFS_INTERNAL_BUS_ARBITER_CTRL;
    wire logic sel_map = reg_addr == chip_cfg_pkg::OFS_REGISTER_BASE_MAPPING;
    wire logic sel_ist = reg_addr == chip_cfg_pkg::OFS_IRQ_STATUS;
    wire logic sel_imk = reg_addr == chip_cfg_pkg::OFS_IRQ_MASK;
    wire logic wr_chip_config = reg_wr && sel_chip_config;
    wire logic wr_ist = reg_wr && sel_ist;

    // Register state.
    logic watchdog_reset_flag_reg, watchdog_reset_pin_enable_reg;
    logic [chip_cfg_pkg::STRAP_W-1:0] boot_strap_bits_reg;
    logic [1:0] timeout_length_sel_reg;
    logic core_timer_irq_disable_reg;
    logic write_timeout_error_flag_reg;
    logic timeout_detect_enable_reg;
    logic [63:0] pin_config_reg, clock_gating_control_reg, internal_bus_arbiter_ctrl_reg;
    logic [63:0] register_base_mapping_reg, timeout_error_addr_reg;
    logic [chip_cfg_pkg::IRQ_W-1:0] irq_status_reg, irq_mask_reg;
    logic [63:0] rdata_reg;
    logic wd_pin_reg;

    // Monitor state.
    mon_state_t state_reg;
    chip_cfg_pkg::gbus_access_t acc_reg;
    logic [chip_cfg_pkg::CNT_W-1:0] cnt_reg;

    // Detection is gated by the enable bit and by an attached probe.
    // R2 enable gate
    // R9 probe disables
    wire logic detect_on = timeout_detect_enable_reg && !trst_sync_reg;

    // R3 limit select
    logic [chip_cfg_pkg::CNT_W-1:0] limit;
    always_comb begin
        unique case (timeout_length_sel_reg)
            2'h0: limit = chip_cfg_pkg::LIMIT_512;
            2'h1: limit = chip_cfg_pkg::LIMIT_1024;
            2'h2: limit = chip_cfg_pkg::LIMIT_2048;
            2'h3: limit = chip_cfg_pkg::LIMIT_4096;
        endcase
    end
    wire logic [chip_cfg_pkg::CNT_W-1:0] limit_m1 = limit - 13'h0001;

    // A new access in the same cycle restarts the monitor, so an old response cannot end it.
    wire logic busy = state_reg == MON_BUSY;
    wire logic acked = busy && gbus_ack && !gbus_start;
    // R4 timeout detect
    // The compare is >= so that enabling late or shortening the limit still ends a stuck access.
    wire logic timeout_hit = busy && !gbus_ack && !gbus_start && detect_on && (cnt_reg >= limit_m1);
    wire logic core_acc = acc_reg.master == chip_cfg_pkg::MST_CORE;

    // R4 error response
    assign gbus_err_resp = timeout_hit;
    // R7 read exception
    assign core_bus_error = timeout_hit && core_acc && !acc_reg.write;
    // R8 other master error
    assign pci_timeout_err = timeout_hit && acc_reg.master == chip_cfg_pkg::MST_PCI;
    assign dma_timeout_err = timeout_hit && acc_reg.master == chip_cfg_pkg::MST_DMA;
    wire logic core_wr_timeout = timeout_hit && core_acc && acc_reg.write;

    // R1 outstanding tracking
    // R14 counter restart
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= MON_IDLE;
            cnt_reg <= 13'h0000;
            acc_reg <= '0;
        end else if (gbus_start) begin
            state_reg <= MON_BUSY;
            cnt_reg <= 13'h0000;
            acc_reg <= gbus_access;
        end else if (acked || timeout_hit) begin
            state_reg <= MON_IDLE;
        end else if (busy && cnt_reg != 13'h1FFF) begin
            cnt_reg <= cnt_reg + 13'h0001;
        end
    end

    // R5 address capture
    always_ff @(posedge mclk) begin
        if (srst) begin
            timeout_error_addr_reg <= 64'h0;
        end else if (timeout_hit) begin
            timeout_error_addr_reg <= {{(64 - chip_cfg_pkg::GBUS_ADDR_W){1'b0}}, acc_reg.addr};
        end
    end

    // Watchdog bits see only the chip reset, so they survive the watchdog reset itself.
    wire logic wd_clear = wr_chip_config && reg_wdata[chip_cfg_pkg::POS_WATCHDOG_RESET_FLAG];
    always_ff @(posedge mclk) begin
        if (srst) begin
            watchdog_reset_flag_reg <= 1'b0;
            watchdog_reset_pin_enable_reg <= 1'b0;
            wd_pin_reg <= 1'b0;
        end else begin
            // R10 watchdog flag
            if (watchdog_reset_req) begin
                watchdog_reset_flag_reg <= 1'b1;
            end else if (wd_clear) begin
                watchdog_reset_flag_reg <= 1'b0;
            end
            // R11 pin enable
            if (wr_chip_config) begin
                watchdog_reset_pin_enable_reg <= reg_wdata[chip_cfg_pkg::POS_WATCHDOG_RESET_PIN_EN];
            end
            wd_pin_reg <= watchdog_reset_req && watchdog_reset_pin_enable_reg;
        end
    end
    // R11 external pin
    assign watchdog_reset_out_n = !wd_pin_reg;

    // Straps are sampled every cycle that a reset is held and frozen at the release.
    wire logic any_rst = srst || boot_rst;
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            // R12 strap latch
            boot_strap_bits_reg <= strap_sync_reg[15:8];
            // R13 timer disable
            core_timer_irq_disable_reg <= !strap_sync_reg[chip_cfg_pkg::STRAP_CORE_TIMER_BIT];
        end
    end
    assign core_timer_irq_disable = core_timer_irq_disable_reg;

    // Writable configuration fields and plain storage registers.
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            timeout_length_sel_reg <= chip_cfg_pkg::TIMEOUT_LENGTH_RESET;
            timeout_detect_enable_reg <= 1'b0;
            pin_config_reg <= 64'h0;
            clock_gating_control_reg <= 64'h0;
            internal_bus_arbiter_ctrl_reg <= 64'h0;
            register_base_mapping_reg <= 64'h0;
            irq_mask_reg <= 3'h0;
        end else if (reg_wr) begin
            if (sel_chip_config) begin
                // R3 length write
                timeout_length_sel_reg <= reg_wdata[chip_cfg_pkg::POS_TIMEOUT_LENGTH_LO +: 2];
                // R2 enable write
                timeout_detect_enable_reg <= reg_wdata[chip_cfg_pkg::POS_TIMEOUT_DETECT_EN];
            end
            if (sel_pin_config) begin
                pin_config_reg <= reg_wdata;
            end
            if (sel_clk) begin
                clock_gating_control_reg <= reg_wdata;
            end
            if (sel_arb) begin
                internal_bus_arbiter_ctrl_reg <= reg_wdata;
            end
            if (sel_map) begin
                register_base_mapping_reg <= reg_wdata;
            end
            if (sel_imk) begin
                irq_mask_reg <= reg_wdata[chip_cfg_pkg::IRQ_W-1:0];
            end
        end
    end

    // Sticky error flags: a new event wins over a write-one clear in the same cycle.
    wire logic [chip_cfg_pkg::IRQ_W-1:0] irq_events = {pci_timeout_err || dma_timeout_err,
                                                       core_bus_error, core_wr_timeout};
    wire logic [chip_cfg_pkg::IRQ_W-1:0] irq_clear = wr_ist ? reg_wdata[chip_cfg_pkg::IRQ_W-1:0] : 3'h0;
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            write_timeout_error_flag_reg <= 1'b0;
            irq_status_reg <= 3'h0;
        end else begin
            // R6 write error flag
            if (core_wr_timeout) begin
                write_timeout_error_flag_reg <= 1'b1;
            end else if (wr_chip_config && reg_wdata[chip_cfg_pkg::POS_WRITE_TIMEOUT_ERR]) begin
                write_timeout_error_flag_reg <= 1'b0;
            end
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
        end
    end
    // R6 interrupt source
    assign write_err_irq = write_timeout_error_flag_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);

    // Chip configuration read view.
    logic [63:0] chip_config_view;
    always_comb begin
        chip_config_view = 64'h0;
        chip_config_view[chip_cfg_pkg::POS_WATCHDOG_RESET_FLAG] = watchdog_reset_flag_reg;
        chip_config_view[chip_cfg_pkg::POS_WATCHDOG_RESET_PIN_EN] = watchdog_reset_pin_enable_reg;
        chip_config_view[chip_cfg_pkg::POS_BOOT_STRAP_LO +: chip_cfg_pkg::STRAP_W] = boot_strap_bits_reg;
        chip_config_view[chip_cfg_pkg::POS_TIMEOUT_LENGTH_LO +: 2] = timeout_length_sel_reg;
        chip_config_view[chip_cfg_pkg::POS_CORE_TIMER_IRQ_DIS] = core_timer_irq_disable_reg;
        chip_config_view[chip_cfg_pkg::POS_WRITE_TIMEOUT_ERR] = write_timeout_error_flag_reg;
        chip_config_view[chip_cfg_pkg::POS_TIMEOUT_DETECT_EN] = timeout_detect_enable_reg;
    end

    // Read mux; unmapped offsets return zero.
    logic [63:0] rd_mux;
    always_comb begin
        rd_mux = 64'h0;
        if (sel_chip_config) rd_mux = chip_config_view;
        if (sel_rev) rd_mux = REVISION_ID;
        if (sel_pin_config) rd_mux = pin_config_reg;
        if (sel_timeout_error_addr) rd_mux = timeout_error_addr_reg;
        if (sel_clk) rd_mux = clock_gating_control_reg;
        if (sel_arb) rd_mux = internal_bus_arbiter_ctrl_reg;
        if (sel_map) rd_mux = register_base_mapping_reg;
        if (sel_ist) rd_mux = {61'h0, irq_status_reg};
        if (sel_imk) rd_mux = {61'h0, irq_mask_reg};
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= 64'h0;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : 64'h0;
        end
    end
    assign reg_rdata = rdata_reg;

    // Checks.
    AST_ERR_NEEDS_ENABLE: assert property (@(posedge mclk) disable iff (srst) // R2
        gbus_err_resp |-> timeout_detect_enable_reg && busy)
        else $error("Error response while detection disabled or idle.");

    AST_PROBE_BLOCKS: assert property (@(posedge mclk) disable iff (srst) // R9
        trst_sync_reg |-> !gbus_err_resp)
        else $error("Timeout reported with a probe attached.");

    AST_LIMIT_COUNT: assert property (@(posedge mclk) disable iff (srst) // R3
        gbus_err_resp |-> cnt_reg >= (chip_cfg_pkg::LIMIT_512 << timeout_length_sel_reg) - 13'h0001)
        else $error("Timeout fired before the selected limit.");

    AST_FIRES_AT_LIMIT: assert property (@(posedge mclk) disable iff (srst || boot_rst) // R4
        busy && detect_on && !gbus_ack && !gbus_start && cnt_reg == limit - 13'h0001 |-> gbus_err_resp ##1 !busy)
        else $error("Timeout missed at the limit.");

    AST_ADDR_CAPTURE: assert property (@(posedge mclk) disable iff (srst) // R5
        gbus_err_resp |=> timeout_error_addr_reg[chip_cfg_pkg::GBUS_ADDR_W-1:0] == $past(acc_reg.addr))
        else $error("Timed-out address not captured.");

    AST_WRITE_FLAG: assert property (@(posedge mclk) disable iff (srst || boot_rst) // R6
        gbus_err_resp && core_acc && acc_reg.write |=> write_err_irq)
        else $error("Core write timeout did not set the flag.");

    AST_READ_EXC: assert property (@(posedge mclk) disable iff (srst || boot_rst) // R7
        core_bus_error && !write_timeout_error_flag_reg && !gbus_start |=> !write_timeout_error_flag_reg)
        else $error("Core read timeout touched the write error flag.");

    AST_OTHER_MASTER: assert property (@(posedge mclk) disable iff (srst) // R8
        gbus_err_resp && !core_acc |-> pci_timeout_err != dma_timeout_err && !core_bus_error)
        else $error("Other master timeout misrouted.");

    AST_STOP_ON_ACK: assert property (@(posedge mclk) disable iff (srst) // R14
        acked |=> !busy && $stable(cnt_reg))
        else $error("Monitor kept running after a response.");

    AST_WD_CLEAR: assert property (@(posedge mclk) disable iff (srst) // R10
        wd_clear && !watchdog_reset_req |=> !watchdog_reset_flag_reg)
        else $error("Watchdog flag not cleared by write one.");

    AST_WD_PIN: assert property (@(posedge mclk) disable iff (srst) // R11
        watchdog_reset_req && !watchdog_reset_pin_enable_reg |=> watchdog_reset_out_n)
        else $error("Watchdog pin asserted while disabled.");

    AST_STRAP_RO: assert property (@(posedge mclk) disable iff (srst || boot_rst) // R12
        wr_chip_config |=> $stable(boot_strap_bits_reg) && $stable(core_timer_irq_disable_reg))
        else $error("Strap bits changed by software.");
endmodule
`default_nettype wire

// >>> dv/gbus_peer.sv
// Behavioural internal bus master and target pair on the far side of the timeout monitor.
`default_nettype none
module gbus_peer (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Bench control
    input wire logic go,
    input wire chip_cfg_pkg::gbus_access_t go_acc,
    input wire logic [12:0] ack_dly,
    // Bus side
    input wire logic gbus_err_resp,
    output logic gbus_start,
    output chip_cfg_pkg::gbus_access_t gbus_access,
    output logic gbus_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic start_q = 1'b0;
    logic ack_q = 1'b0;
    logic busy = 1'b0;
    logic [12:0] cnt = 13'h0000;
    chip_cfg_pkg::gbus_access_t acc_q = '0;
    assign gbus_start = start_q;
    assign gbus_ack = ack_q;
    assign gbus_access = acc_q;
    always @(posedge mclk) begin
        start_q <= go & ~srst;
        ack_q <= 1'b0;
        if (srst) begin
            busy <= 1'b0;
            cnt <= 13'h0000;
        end else if (go) begin
            acc_q <= go_acc;
            busy <= 1'b1;
            cnt <= 13'h0000;
        end else begin
            // The address and write qualifiers mean nothing after the start pulse, so they are scrambled; the master is kept.
            if (start_q) begin
                acc_q.addr <= ~acc_q.addr;
                acc_q.write <= ~acc_q.write;
            end
            if (busy && ack_dly != 13'h0000 && cnt + 13'h0001 == ack_dly) begin
                ack_q <= 1'b1;
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt + 13'h0001;
            end
            if (gbus_err_resp) begin
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the chip configuration block and its bus timeout monitor.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] a;
        logic w;
        logic [63:0] d;
        logic [63:0] m;
        logic [63:0] e;
    } row_t;
    localparam logic [63:0] CM = 64'h0000_03FF_0701_4000;
    localparam logic [63:0] FF = 64'hFFFF_FFFF_FFFF_FFFF;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic boot_rst = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [63:0] reg_wdata = 64'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [63:0] reg_rdata;
    logic go = 1'b0;
    chip_cfg_pkg::gbus_access_t go_acc = '0;
    chip_cfg_pkg::gbus_access_t gbus_access;
    logic [12:0] ack_dly = 13'h0000;
    logic gbus_start, gbus_ack, err, core_err, pci_err, dma_err;
    logic jtag_trst_n = 1'b0;
    logic [15:0] strap = 16'hA55A;
    logic wd_req = 1'b0;
    logic wd_out_n, tmr_dis, wr_irq, irq;
    int n_errors = 0;
    int check_count = 0;
    row_t rows [9] = '{
        '{chip_cfg_pkg::OFS_CHIP_CONFIG, 1'b0, 64'h0, CM, 64'h0000_00A5_0700_0000},
        '{chip_cfg_pkg::OFS_CHIP_REVISION_ID, 1'b1, FF, FF, 64'h0000_0000_0000_00C3},
        '{chip_cfg_pkg::OFS_PIN_CONFIG, 1'b1, 64'h0123_4567_89AB_CDEF, FF, 64'h0123_4567_89AB_CDEF},
        '{chip_cfg_pkg::OFS_CLOCK_GATING_CONTROL, 1'b1, FF, FF, FF},
        '{chip_cfg_pkg::OFS_INTERNAL_BUS_ARBITER_CTRL, 1'b1, 64'hA5A5_0000_5A5A_FFFF, FF, 64'hA5A5_0000_5A5A_FFFF},
        '{chip_cfg_pkg::OFS_REGISTER_BASE_MAPPING, 1'b1, 64'h8000_0000_0000_0001, FF, 64'h8000_0000_0000_0001},
        '{16'hE040, 1'b1, FF, FF, 64'h0},
        '{chip_cfg_pkg::OFS_CHIP_CONFIG, 1'b1, FF, CM, 64'h0000_01A5_0700_4000},
        '{chip_cfg_pkg::OFS_IRQ_MASK, 1'b1, 64'h7, 64'h7, 64'h7}
    };
    always #2.5 mclk = ~mclk;
    chip_config_bus_timeout #(.REVISION_ID(64'h0000_0000_0000_00C3)) u_dut (.mclk(mclk), .srst(srst),
        .boot_rst(boot_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .gbus_start(gbus_start), .gbus_access(gbus_access), .gbus_ack(gbus_ack),
        .gbus_err_resp(err), .core_bus_error(core_err), .pci_timeout_err(pci_err), .dma_timeout_err(dma_err),
        .jtag_trst_n(jtag_trst_n), .strap_data(strap), .watchdog_reset_req(wd_req),
        .watchdog_reset_out_n(wd_out_n), .core_timer_irq_disable(tmr_dis), .write_err_irq(wr_irq), .irq(irq));
    gbus_peer u_peer (.mclk(mclk), .srst(srst), .go(go), .go_acc(go_acc), .ack_dly(ack_dly),
        .gbus_err_resp(err), .gbus_start(gbus_start), .gbus_access(gbus_access), .gbus_ack(gbus_ack));
    task automatic chk(input logic [63:0] seen, input logic [63:0] want, input string what);
        check_count++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [63:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [63:0] m, input logic [63:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e, "read data");
    endtask
    function automatic logic [63:0] cfg(input logic [1:0] len, input logic en);
        return {24'h0, 13'h0, len, 10'h0, en, 14'h0};
    endfunction
    // One access; want is the error cycle after start, or 0 when no error may come within lim cycles.
    task automatic acc(input chip_cfg_pkg::bus_master_t m, input logic w, input logic [12:0] dly,
        input int lim, input int want);
        int n;
        @(posedge mclk);
        go <= 1'b1;
        go_acc <= '{addr: {33'h1_2345_6789, w, m}, write: w, master: m};
        ack_dly <= dly;
        @(posedge mclk);
        go <= 1'b0;
        @(negedge mclk);
        n = 0;
        while (n < lim && err !== 1'b1) begin
            @(negedge mclk);
            n++;
        end
        if (err !== 1'b1) n = 0;
        chk(64'(n), 64'(want), "error cycle");
        if (n != 0) begin
            chk(core_err, m == chip_cfg_pkg::MST_CORE && !w, "core fault");
            chk(pci_err, m == chip_cfg_pkg::MST_PCI, "pci fault");
            chk(dma_err, m == chip_cfg_pkg::MST_DMA, "dma fault");
            @(negedge mclk);
            chk(err, 1'b0, "error pulse");
            rd(chip_cfg_pkg::OFS_TIMEOUT_ERROR_ADDR, 64'hF_FFFF_FFFF, {28'h0, 33'h1_2345_6789, w, m});
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #300us;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        chk(tmr_dis, 1'b1, "timer irq disable");
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].m, rows[i].e);
        end
        @(posedge mclk);
        wd_req <= 1'b1;
        @(posedge mclk);
        wd_req <= 1'b0;
        #1;
        chk(wd_out_n, 1'b0, "watchdog pin");
        @(posedge mclk);
        boot_rst <= 1'b1;
        repeat (4) @(posedge mclk);
        boot_rst <= 1'b0;
        rd(chip_cfg_pkg::OFS_CHIP_CONFIG, CM, 64'h0000_03A5_0700_0000);
        wr(chip_cfg_pkg::OFS_CHIP_CONFIG, 64'h0000_0200_0000_0000);
        rd(chip_cfg_pkg::OFS_CHIP_CONFIG, 64'h0000_0300_0000_0000, 64'h0);
        @(posedge mclk);
        wd_req <= 1'b1;
        repeat (2) @(posedge mclk);
        wd_req <= 1'b0;
        #1;
        chk(wd_out_n, 1'b1, "watchdog pin off");
        wr(chip_cfg_pkg::OFS_IRQ_MASK, 64'h7);
        wr(chip_cfg_pkg::OFS_CHIP_CONFIG, cfg(2'b00, 1'b1));
        acc(chip_cfg_pkg::MST_CORE, 1'b1, 13'h0000, 600, 512);
        @(negedge mclk);
        chk(wr_irq, 1'b1, "write error irq");
        chk(irq, 1'b1, "irq");
        rd(chip_cfg_pkg::OFS_CHIP_CONFIG, 64'h1_0000, 64'h1_0000);
        rd(chip_cfg_pkg::OFS_IRQ_STATUS, 64'h7, 64'h1);
        wr(chip_cfg_pkg::OFS_CHIP_CONFIG, cfg(2'b00, 1'b1) | 64'h1_0000);
        wr(chip_cfg_pkg::OFS_IRQ_STATUS, 64'h1);
        @(negedge mclk);
        chk({wr_irq, irq}, 2'b00, "irq cleared");
        acc(chip_cfg_pkg::MST_CORE, 1'b0, 13'h0000, 600, 512);
        acc(chip_cfg_pkg::MST_PCI, 1'b1, 13'h0000, 600, 512);
        acc(chip_cfg_pkg::MST_DMA, 1'b0, 13'h0000, 600, 512);
        chk(wr_irq, 1'b0, "no write flag on reads");
        wr(chip_cfg_pkg::OFS_IRQ_MASK, 64'h1);
        @(negedge mclk);
        chk(irq, 1'b0, "masked irq");
        wr(chip_cfg_pkg::OFS_IRQ_MASK, 64'h4);
        @(negedge mclk);
        chk(irq, 1'b1, "unmasked irq");
        wr(chip_cfg_pkg::OFS_IRQ_STATUS, 64'h7);
        @(negedge mclk);
        chk(irq, 1'b0, "status cleared");
        acc(chip_cfg_pkg::MST_CORE, 1'b1, 13'h01FF, 600, 0);
        for (int len = 1; len < 4; len++) begin
            wr(chip_cfg_pkg::OFS_CHIP_CONFIG, cfg(2'(len), 1'b1));
            acc(chip_cfg_pkg::MST_PCI, 1'b1, 13'h0000, 4200, 512 << len);
        end
        wr(chip_cfg_pkg::OFS_CHIP_CONFIG, cfg(2'b00, 1'b0));
        acc(chip_cfg_pkg::MST_DMA, 1'b1, 13'h0000, 600, 0);
        wr(chip_cfg_pkg::OFS_CHIP_CONFIG, cfg(2'b00, 1'b1));
        // The stalled access is already past the limit, so enabling ends it at once.
        @(negedge mclk);
        chk(dma_err, 1'b1, "late enable ends stuck access");
        @(posedge mclk);
        jtag_trst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        acc(chip_cfg_pkg::MST_CORE, 1'b0, 13'h0000, 600, 0);
        give_verdict();
    end
endmodule
`default_nettype wire
